// ===== tb/erdm_ahb_mem.sv
// Behavioural system memory and bus arbiter on the far side of the AHB master
`timescale 1ns/1ps
`default_nettype none
module erdm_ahb_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic berr,
  input wire logic hbusreq,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  output logic hgrant,
  output logic hready,
  output logic [31:0] hrdata,
  output logic [1:0] hresp
);
  import erdm_pkg::*;
  logic [31:0] mem [0:4095];
  logic dpAct;
  logic dpWr;
  logic errAct;
  logic [11:0] dpIdx;
  logic [1:0] waitCnt;
  logic [1:0] w;
  int seed = 90;
  // Berr turns every write data phase into an error response
  assign hresp = errAct ? 2'h1 : HRESP_OKAY;
  always @(posedge clk) begin
    // Read data is only meaningful in a read data phase, so outside reset it never rests
    hrdata <= ~hrdata;
    if (rst) begin
      hgrant <= 1'h0;
      hready <= 1'h1;
      dpAct <= 1'h0;
      errAct <= 1'h0;
      hrdata <= 32'h0000_0000;
    end else begin
      // Stall models a late grant from the arbiter
      hgrant <= hbusreq && !stall;
      if (dpAct && hready) begin
        if (dpWr) mem[dpIdx] <= hwdata;
        dpAct <= 1'h0;
        errAct <= 1'h0;
      end
      if (hready && htrans == HTRANS_NONSEQ) begin
        w = 2'($random(seed));
        dpAct <= 1'h1;
        dpWr <= hwrite;
        errAct <= berr && hwrite;
        dpIdx <= haddr[13:2];
        waitCnt <= w;
        hready <= w == 2'h0;
        if (w == 2'h0) hrdata <= mem[haddr[13:2]];
      end else if (dpAct && !hready) begin
        if (waitCnt == 2'h1) begin
          hready <= 1'h1;
          hrdata <= mem[dpIdx];
        end
        waitCnt <= waitCnt - 2'h1;
      end
    end
  end
endmodule : erdm_ahb_mem
`default_nettype wire

// ===== tb/erdm_rx_desc_mgr_tb_top.sv
// Self-checking bench for the receive descriptor manager
`timescale 1ns/1ps
`default_nettype none
module erdm_rx_desc_mgr_tb_top;
  import erdm_pkg::*;
  typedef struct packed {logic [31:0] a; logic [31:0] d;} erdm_wr_t;
  localparam logic [31:0] BASE = 32'h0000_0100;
  logic clk, rst, rxEnable, qPtrWe, rxValid, rxReady, filtValid, filtCopy, stall, berr;
  logic bufNotAvail, resErrInc, overrun, hbusreq, hgrant, hwrite, hready;
  logic [31:0] netCfg, qPtrWdata, qPtrValue, haddr, hwdata, hrdata, dpA;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize, hburst;
  logic dpW = 1'h0;
  logic chkOn = 1'h1;
  erdm_rxw_t rxIn;
  erdm_wr_t expQ[$];
  logic [31:0] fw [0:63];
  int errCount = 0, numChecks = 0, seed = 90, cyc = 0;
  int nBna = 0, nRes = 0, nOvr = 0, nRef = 0, dIdx = 0;

  erdm_rx_desc_mgr DUT (.clk, .rst, .rxEnable, .netCfg, .qPtrWe, .qPtrWdata, .qPtrValue,
    .rxIn, .rxValid, .rxReady, .filtValid, .filtCopy, .bufNotAvail, .resErrInc, .overrun,
    .hbusreq, .hgrant, .haddr, .htrans, .hwrite, .hsize, .hburst, .hwdata, .hrdata,
    .hready, .hresp);
  erdm_ahb_mem MEM (.clk, .rst, .stall, .berr, .hbusreq, .haddr, .htrans, .hwrite, .hwdata,
    .hgrant, .hready, .hrdata, .hresp);

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic finalReport();
    $display("Checks %0d errors %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finalReport

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chkWr(input logic [31:0] a, input logic [31:0] d);
    erdm_wr_t e;
    e = '{32'hFFFF_FFFF, 32'h0000_0000};
    if (expQ.size() != 0) e = expQ.pop_front();
    chk(a, e.a);
    chk(d, e.d);
  endtask : chkWr

  function automatic logic [31:0] bufAddr(input int i);
    return 32'h0000_1000 + 32'(i) * 32'h0000_0080;
  endfunction : bufAddr

  task automatic initDesc();
    for (int i = 0; i < 3; i++) begin
      MEM.mem[(BASE >> 2) + 2 * i] = bufAddr(i) | (i == 2 ? 32'h0000_0002 : 32'h0000_0000);
      MEM.mem[(BASE >> 2) + 2 * i + 1] = 32'h0000_0000;
    end
  endtask : initDesc

  task automatic randFill();
    for (int i = 0; i < 64; i++) fw[i] = $random(seed);
    fw[3][15:0] = 16'h0008;
  endtask : randFill

  task automatic sendFrame(input int nw, input logic [13:0] nb, input logic [9:0] m,
                           input bit fcsLast, input bit lossy);
    for (int i = 0; i < nw; i++) begin
      @(negedge clk);
      // A word shown while the FIFO is full counts as lost, so hold valid off
      while (!rxReady && !lossy) begin
        rxValid = 1'h0;
        @(negedge clk);
      end
      rxValid = 1'h1;
      rxIn = '{m, nb, 1'h0, fcsLast && i == nw - 1, i == nw - 1, fw[i]};
    end
    @(negedge clk);
    rxValid = 1'h0;
  endtask : sendFrame

  // Mode 0 copies and expects writes, 1 is a filter reject, 2 expects a drop
  task automatic frame(input int nw, input logic [13:0] nb, input bit fcsLast, input int mode);
    logic [9:0] m;
    logic [13:0] ln;
    logic [31:0] st, da;
    int k, cap, nd;
    bit first;
    m = 10'($random(seed));
    ln = netCfg[CFG_NOFCS] ? nb - FCS_BYTES : nb;
    nd = (fcsLast && netCfg[CFG_NOFCS]) ? nw - 1 : nw;
    cap = netCfg[15:14] != 2'h0 ? 31 : 32;
    k = 0;
    first = 1;
    filtCopy = mode != 1;
    for (int i = 0; i < nd && mode == 0; i++) begin
      expQ.push_back('{bufAddr(dIdx) + 32'(4 * k), fw[i]});
      k++;
      if (k == cap || i == nd - 1) begin
        st = 32'(first) << ST_SOF | 32'(netCfg[15:14]) << ST_HI_LSB;
        if (i == nd - 1) begin
          st = st | 32'h0000_8000 | 32'(m) << ST_MATCH_LSB | 32'(ln[11:0]);
          if (netCfg[CFG_JUMBO]) st[13:12] = ln[13:12];
          if (fw[3][15:0] == 16'h0081)
            st[21:16] = {1'h1, {fw[3][19:16], fw[3][31:24]} == 12'h000, fw[3][23:20]};
        end
        da = BASE + 32'(8 * dIdx);
        expQ.push_back('{da, MEM.mem[da >> 2] | 32'h0000_0001});
        expQ.push_back('{da + 32'h0000_0004, st});
        dIdx = MEM.mem[da >> 2][DESC_WRAP] ? 0 : dIdx + 1;
        k = 0;
        first = 0;
        cap = 32;
      end
    end
    sendFrame(nw, nb, m, fcsLast, 0);
    for (int i = 0; i < 4000 && (expQ.size() != 0 || (mode != 0 && i < 200)); i++) @(posedge clk);
    // Let the counter step after the last status write
    repeat (8) @(negedge clk);
    chk(32'(expQ.size()), 32'h0000_0000);
    chk(qPtrValue, BASE + 32'(8 * dIdx));
  endtask : frame

  always @(posedge clk) begin
    cyc++;
    if (bufNotAvail) nBna++;
    if (bufNotAvail && resErrInc) nRes++;
    if (overrun) nOvr++;
    if (rxValid && !rxReady) nRef++;
    if (htrans == HTRANS_NONSEQ) chk({26'h0, hsize, hburst}, {26'h0, HSIZE_WORD, HBURST_SINGLE});
    if (hready && dpW && chkOn) chkWr(dpA, hwdata);
    if (hready) begin
      dpW <= htrans == HTRANS_NONSEQ && hwrite;
      dpA <= haddr;
    end
    if (cyc == 30000) begin
      errCount++;
      finalReport();
    end
  end

  initial begin
    rst = 1'h1;
    rxEnable = 1'h0;
    netCfg = 32'h0000_0000;
    qPtrWe = 1'h0;
    qPtrWdata = 32'h0000_0000;
    rxValid = 1'h0;
    rxIn = '0;
    filtValid = 1'h1;
    filtCopy = 1'h1;
    stall = 1'h0;
    berr = 1'h0;
    initDesc();
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    qPtrWdata = BASE;
    qPtrWe = 1'h1;
    @(negedge clk);
    qPtrWe = 1'h0;
    rxEnable = 1'h1;
    chk(qPtrValue, BASE);
    // Tagged frame with priority, canonical bit and a nonzero identifier
    randFill();
    fw[3] = 32'h23B1_0081;
    frame(16, 14'h0040, 0, 0);
    // Priority-only tag, first buffer offset by two bytes
    netCfg = 32'h0000_8000;
    randFill();
    fw[3] = 32'h0060_0081;
    frame(16, 14'h0040, 0, 0);
    // Two buffers across the wrap entry, jumbo length, FCS stripped
    initDesc();
    netCfg = 32'h0002_0008;
    randFill();
    frame(40, 14'h10A0, 1, 0);
    netCfg = 32'h0000_0000;
    randFill();
    frame(8, 14'h0020, 0, 1);
    // Descriptor already owned by software-side processing
    MEM.mem[(BASE >> 2) + 2 * dIdx] = MEM.mem[(BASE >> 2) + 2 * dIdx] | 32'h0000_0001;
    randFill();
    frame(8, 14'h0020, 0, 2);
    chk(32'(nBna), 32'h0000_0001);
    chk(32'(nRes), 32'h0000_0001);
    MEM.mem[(BASE >> 2) + 2 * dIdx] = MEM.mem[(BASE >> 2) + 2 * dIdx] & 32'hFFFF_FFFE;
    // Late grant: the FIFO fills, refuses and the frame is lost
    stall = 1'h1;
    chkOn = 1'h0;
    randFill();
    sendFrame(16, 14'h0040, 10'h000, 0, 1);
    stall = 1'h0;
    repeat (300) @(negedge clk);
    chkOn = 1'h1;
    chk(32'(nRef != 0), 32'h0000_0001);
    chk(32'(nOvr != 0), 32'h0000_0001);
    // Bus error on a data write: one overrun pulse, buffer reclaimed, pointer kept
    berr = 1'h1;
    chkOn = 1'h0;
    nOvr = 0;
    randFill();
    sendFrame(8, 14'h0020, 10'h000, 0, 0);
    repeat (200) @(negedge clk);
    berr = 1'h0;
    chkOn = 1'h1;
    chk(32'(nOvr), 32'h0000_0001);
    chk(qPtrValue, BASE + 32'(8 * dIdx));
    // The reclaimed buffer serves the next frame
    randFill();
    frame(16, 14'h0040, 0, 0);
    finalReport();
  end
endmodule : erdm_rx_desc_mgr_tb_top
`default_nettype wire

// ===== verilog/erdm_fifo.sv
// Flop-based FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module erdm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrReg;
  logic [AW-1:0] rdReg;
  logic [AW:0] cntReg;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  assign inReady = cntReg != (AW+1)'(DEPTH);
  assign outValid = cntReg != '0;
  assign outData = mem[rdReg];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrReg] <= inData;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wrReg <= '0;
      rdReg <= '0;
      cntReg <= '0;
    end else begin
      wrReg <= push ? AW'((32'(wrReg) + 1) % DEPTH) : wrReg;
      rdReg <= pop ? AW'((32'(rdReg) + 1) % DEPTH) : rdReg;
      cntReg <= cntReg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : erdm_fifo
`default_nettype wire

// ===== verilog/erdm_pkg.sv
// Constants and types for the receive descriptor manager
package erdm_pkg;
  localparam int DESC_USED = 0;
  localparam int DESC_WRAP = 1;
  localparam int ST_MATCH_LSB = 22;
  localparam int ST_VLAN = 21;
  localparam int ST_PRIO_TAG = 20;
  localparam int ST_PRI_LSB = 17;
  localparam int ST_CFI = 16;
  localparam int ST_EOF = 15;
  localparam int ST_SOF = 14;
  localparam int ST_HI_LSB = 12;
  localparam int CFG_JUMBO = 3;
  localparam int CFG_OFF_LSB = 14;
  localparam int CFG_NOFCS = 17;
  localparam logic [15:0] VLAN_TPID = 16'h8100;
  localparam logic [13:0] FCS_BYTES = 14'h0004;
  localparam logic [5:0] BUF_WORDS = 6'h20;
  localparam logic [10:0] DESC_STEP = 11'h002;
  localparam logic [2:0] TAG_WORD = 3'h3;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef struct packed {
    logic [9:0] match;
    logic [13:0] len;
    logic err;
    logic fcsOnly;
    logic last;
    logic [31:0] data;
  } erdm_rxw_t;

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_FILT, S_DATA, S_DESC0, S_DESC1, S_DROP}
    erdm_state_t;
  typedef enum logic [1:0] {B_IDLE, B_ADDR, B_DATA} erdm_bus_t;
endpackage : erdm_pkg

// ===== verilog/erdm_rx_desc_mgr.sv
// Receive descriptor manager: walks the list and writes frames to memory
`timescale 1ns/1ps
`default_nettype none
module erdm_rx_desc_mgr (
  input wire logic clk,
  input wire logic rst,
  input wire logic rxEnable,
  input wire logic [31:0] netCfg,
  input wire logic qPtrWe,
  input wire logic [31:0] qPtrWdata,
  output logic [31:0] qPtrValue,
  input wire erdm_pkg::erdm_rxw_t rxIn,
  input wire logic rxValid,
  output logic rxReady,
  input wire logic filtValid,
  input wire logic filtCopy,
  output logic bufNotAvail,
  output logic resErrInc,
  output logic overrun,
  output logic hbusreq,
  input wire logic hgrant,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [2:0] hburst,
  output logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hready,
  input wire logic [1:0] hresp
);
  import erdm_pkg::*;

  erdm_state_t stateReg, stateNext;
  erdm_bus_t busReg;
  logic [29:0] qBaseReg;
  logic [10:0] cntReg;
  logic [29:0] bufAddrReg;
  logic wrapReg;
  logic [5:0] wordCntReg;
  logic sofReg;
  logic eofReg;
  logic lastIssuedReg;
  logic [13:0] lenReg;
  logic [9:0] matchReg;
  logic inDropReg;
  logic pendMarkReg;
  logic bnaReg;
  logic resReg;
  logic ovrReg;
  logic [31:0] haddrReg;
  logic [1:0] htransReg;
  logic hwriteReg;
  logic [31:0] hwdataReg;
  logic [31:0] statusWord;

  // Input side: the MAC cannot stall, so a full FIFO means overrun
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;
  logic [$bits(erdm_rxw_t)-1:0] fifoOut;
  erdm_rxw_t marker;
  erdm_rxw_t head;
  assign marker = '{match: '0, len: '0, err: 1'b1, fcsOnly: 1'b0, last: 1'b1, data: '0};
  wire inLost = rxValid && !rxReady && !inDropReg;
  wire fifoPush = pendMarkReg || (rxValid && !inDropReg);
  assign rxReady = fifoInReady && !pendMarkReg;

  erdm_fifo #(.WIDTH($bits(erdm_rxw_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData(pendMarkReg ? marker : rxIn),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOut)
  );
  assign head = erdm_rxw_t'(fifoOut);

  // Descriptor pointer and buffer fill decode
  wire [31:0] descAddr = {qBaseReg, 2'h0} + {19'h0, cntReg, 2'h0};
  assign qPtrValue = descAddr;
  wire [1:0] cfgOffset = netCfg[CFG_OFF_LSB +: 2];
  wire [5:0] bufCap = (sofReg && cfgOffset != '0) ? BUF_WORDS - 6'h01 : BUF_WORDS;
  wire bufFull = wordCntReg == bufCap;
  wire skipWord = head.fcsOnly && netCfg[CFG_NOFCS];
  wire busIdle = busReg == B_IDLE;
  wire dataReady = stateReg == S_DATA && busIdle && fifoOutValid;
  wire dataWrite = dataReady && !head.err && !skipWord && !bufFull;

  // One bus operation at a time; single word transfers only
  logic opReq;
  logic [31:0] opAddr;
  logic [31:0] opWdata;
  always_comb begin
    opReq = 1'b0;
    opAddr = descAddr;
    opWdata = '0;
    unique case (stateReg)
      S_FETCH: opReq = busIdle;
      S_DATA: begin
        opReq = dataWrite;
        opAddr = {bufAddrReg + 30'(wordCntReg), 2'h0};
        opWdata = head.data;
      end
      S_DESC0: begin
        opReq = busIdle;
        opWdata = {bufAddrReg, wrapReg, 1'b1};
      end
      S_DESC1: begin
        opReq = busIdle;
        opAddr = descAddr + WORD_BYTES;
        opWdata = statusWord;
      end
      S_IDLE, S_FILT, S_DROP: opReq = 1'b0;
    endcase
  end
  wire issue = opReq && hgrant && hready;
  wire busDone = busReg == B_DATA && hready;
  wire busErr = busDone && hresp != HRESP_OKAY;
  assign hbusreq = opReq;
  assign haddr = haddrReg;
  assign htrans = htransReg;
  assign hwrite = hwriteReg;
  assign hwdata = hwdataReg;
  assign hsize = HSIZE_WORD;
  assign hburst = HBURST_SINGLE;

  assign fifoPop = (stateReg == S_DATA && issue)
                || (dataReady && (head.err || skipWord))
                || (stateReg == S_DROP && fifoOutValid);
  wire frameStart = stateReg == S_IDLE && stateNext == S_FETCH;

  erdm_status_word u_status (
    .clk(clk),
    .rst(rst),
    .frameStart(frameStart),
    .popEn(fifoPop && stateReg == S_DATA),
    .popData(head.data),
    .sof(sofReg),
    .eof(eofReg),
    .netCfg(netCfg),
    .len(lenReg),
    .match(matchReg),
    .status(statusWord)
  );

  // Frame flow
  always_comb begin
    stateNext = stateReg;
    unique case (stateReg)
      S_IDLE: if (fifoOutValid) begin
        stateNext = rxEnable ? S_FETCH : S_DROP;
      end
      S_FETCH: if (busErr) begin
        stateNext = S_DROP;
      end else if (busDone) begin
        if (hrdata[DESC_USED]) begin
          stateNext = S_DROP;
        end else begin
          stateNext = sofReg ? S_FILT : S_DATA;
        end
      end
      S_FILT: if (filtValid) begin
        stateNext = filtCopy ? S_DATA : S_DROP;
      end
      S_DATA: if (busDone) begin
        if (busErr) begin
          stateNext = lastIssuedReg ? S_IDLE : S_DROP;
        end else if (lastIssuedReg) begin
          stateNext = S_DESC0;
        end
      end else if (dataReady) begin
        if (head.err) begin
          stateNext = S_IDLE;
        end else if ((skipWord && head.last) || (!skipWord && bufFull)) begin
          stateNext = S_DESC0;
        end
      end
      S_DESC0: if (busErr) begin
        stateNext = eofReg ? S_IDLE : S_DROP;
      end else if (busDone) begin
        stateNext = S_DESC1;
      end
      S_DESC1: if (busErr) begin
        stateNext = eofReg ? S_IDLE : S_DROP;
      end else if (busDone) begin
        stateNext = eofReg ? S_IDLE : S_FETCH;
      end
      S_DROP: if (fifoOutValid && head.last) begin
        stateNext = S_IDLE;
      end
    endcase
  end

  wire closeLast = dataReady && skipWord && head.last;
  wire advance = stateReg == S_DESC1 && busDone && !busErr;
  wire fetchOk = stateReg == S_FETCH && busDone && !busErr && !hrdata[DESC_USED];

  always_ff @(posedge clk) begin
    if (rst) begin
      stateReg <= S_IDLE;
      busReg <= B_IDLE;
      htransReg <= HTRANS_IDLE;
      haddrReg <= '0;
      hwriteReg <= 1'b0;
      hwdataReg <= '0;
    end else begin
      stateReg <= stateNext;
      if (busIdle && issue) begin
        busReg <= B_ADDR;
        htransReg <= HTRANS_NONSEQ;
        haddrReg <= opAddr;
        hwriteReg <= stateReg != S_FETCH;
        hwdataReg <= opWdata;
      end else if (busReg == B_ADDR && hready) begin
        busReg <= B_DATA;
        htransReg <= HTRANS_IDLE;
      end else if (busDone) begin
        busReg <= B_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || qPtrWe) begin
      cntReg <= '0;
    end else if (advance) begin
      cntReg <= wrapReg ? '0 : cntReg + DESC_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      qBaseReg <= '0;
    end else if (qPtrWe) begin
      qBaseReg <= qPtrWdata[31:2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bufAddrReg <= '0;
      wrapReg <= 1'b0;
    end else if (fetchOk) begin
      bufAddrReg <= hrdata[31:2];
      wrapReg <= hrdata[DESC_WRAP];
    end
  end

  always_ff @(posedge clk) begin
    if (rst || frameStart) begin
      sofReg <= ~rst;
      eofReg <= 1'b0;
      wordCntReg <= '0;
      lastIssuedReg <= 1'b0;
    end else begin
      if (advance) begin
        sofReg <= 1'b0;
        wordCntReg <= '0;
      end else if (stateReg == S_DATA && busDone && !busErr) begin
        wordCntReg <= wordCntReg + 6'h01;
      end
      if (stateReg == S_DATA && issue) begin
        lastIssuedReg <= head.last;
      end
      if ((stateReg == S_DATA && busDone && lastIssuedReg) || closeLast) begin
        eofReg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lenReg <= '0;
      matchReg <= '0;
    end else if (fifoPop && head.last) begin
      lenReg <= head.len;
      matchReg <= head.match;
    end
  end

  // A lost word poisons the rest of its frame; an error marker ends it
  always_ff @(posedge clk) begin
    if (rst) begin
      inDropReg <= 1'b0;
      pendMarkReg <= 1'b0;
    end else begin
      if (inLost) begin
        inDropReg <= !rxIn.last;
        pendMarkReg <= rxIn.last;
      end else if (inDropReg && rxValid && rxIn.last) begin
        inDropReg <= 1'b0;
        pendMarkReg <= 1'b1;
      end else if (pendMarkReg && fifoInReady) begin
        pendMarkReg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bnaReg <= 1'b0;
      resReg <= 1'b0;
      ovrReg <= 1'b0;
    end else begin
      bnaReg <= stateReg == S_FETCH && busDone && !busErr && hrdata[DESC_USED];
      resReg <= stateReg == S_FETCH && busDone && !busErr && hrdata[DESC_USED];
      ovrReg <= inLost || busErr;
    end
  end
  assign bufNotAvail = bnaReg;
  assign resErrInc = resReg;
  assign overrun = ovrReg;

  a_used_mark: assert property (@(posedge clk) disable iff (rst)
    issue && stateReg == S_DESC0 |=> hwrite && hwdata[DESC_USED] && htrans == HTRANS_NONSEQ)
    else $error("used bit not written");
  a_bna_flag: assert property (@(posedge clk) disable iff (rst)
    stateReg == S_FETCH && busDone && hresp == HRESP_OKAY && hrdata[DESC_USED]
    |=> bufNotAvail ##1 !bufNotAvail)
    else $error("buffer not available not flagged");
  a_used_drop: assert property (@(posedge clk) disable iff (rst)
    stateReg == S_FETCH && busDone && hresp == HRESP_OKAY && hrdata[DESC_USED]
    |=> resErrInc && stateReg == S_DROP)
    else $error("frame not dropped on used descriptor");
  a_wrap_restart: assert property (@(posedge clk) disable iff (rst || qPtrWe)
    advance && wrapReg |=> cntReg == '0)
    else $error("counter not cleared after wrap");
  a_next_entry: assert property (@(posedge clk) disable iff (rst || qPtrWe)
    advance && !wrapReg |=> cntReg == 11'($past(cntReg) + DESC_STEP))
    else $error("pointer did not step one descriptor");
  a_ptr_readback: assert property (@(posedge clk) disable iff (rst)
    qPtrWe |=> qPtrValue == {$past(qPtrWdata[31:2]), 2'h0})
    else $error("pointer readback wrong after load");
  a_filter_first: assert property (@(posedge clk) disable iff (rst)
    $rose(stateReg == S_DATA) && sofReg |-> $past(filtValid && filtCopy))
    else $error("data write before filter decision");
  a_fetch_start: assert property (@(posedge clk) disable iff (rst)
    stateReg == S_IDLE && rxEnable && fifoOutValid |=> stateReg == S_FETCH ##1 hbusreq)
    else $error("no descriptor fetch on frame arrival");
  a_bus_overrun: assert property (@(posedge clk) disable iff (rst)
    busErr |=> overrun && !advance)
    else $error("bus error not reported as overrun");
  a_buffer_size: assert property (@(posedge clk) disable iff (rst)
    wordCntReg <= BUF_WORDS)
    else $error("buffer overfilled");
  c_whole_frame: cover property (@(posedge clk) disable iff (rst)
    advance && eofReg && sofReg);
  c_multi_buffer: cover property (@(posedge clk) disable iff (rst)
    advance && !eofReg);
  c_used_seen: cover property (@(posedge clk) disable iff (rst) bufNotAvail);
  c_wrap_taken: cover property (@(posedge clk) disable iff (rst) advance && wrapReg);
endmodule : erdm_rx_desc_mgr
`default_nettype wire

// ===== verilog/erdm_status_word.sv
// Builds the descriptor status word and watches for a VLAN tag
`timescale 1ns/1ps
`default_nettype none
module erdm_status_word (
  input wire logic clk,
  input wire logic rst,
  input wire logic frameStart,
  input wire logic popEn,
  input wire logic [31:0] popData,
  input wire logic sof,
  input wire logic eof,
  input wire logic [31:0] netCfg,
  input wire logic [13:0] len,
  input wire logic [9:0] match,
  output logic [31:0] status
);
  import erdm_pkg::*;
  logic [2:0] idxReg;
  logic [31:0] tagReg;
  // Type field sits in bytes 12-13, tag control in 14-15, network order
  wire [15:0] typeId = {tagReg[7:0], tagReg[15:8]};
  wire [15:0] tci = {tagReg[23:16], tagReg[31:24]};
  wire vlan = idxReg > TAG_WORD && typeId == VLAN_TPID;
  wire [13:0] lenAdj = netCfg[CFG_NOFCS] ? len - FCS_BYTES : len;
  wire [1:0] hiBits = (netCfg[CFG_JUMBO] && eof) ? lenAdj[13:12]
                                                  : netCfg[CFG_OFF_LSB +: 2];
  always_ff @(posedge clk) begin
    if (rst || frameStart) begin
      idxReg <= '0;
    end else if (popEn && idxReg <= TAG_WORD) begin
      idxReg <= idxReg + 3'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      tagReg <= '0;
    end else if (popEn && idxReg == TAG_WORD) begin
      tagReg <= popData;
    end
  end
  always_comb begin
    status = '0;
    status[ST_SOF] = sof;
    status[ST_HI_LSB +: 2] = hiBits;
    if (eof) begin
      status[ST_MATCH_LSB +: 10] = match;
      status[ST_VLAN] = vlan;
      status[ST_PRIO_TAG] = vlan && tci[11:0] == '0;
      status[ST_PRI_LSB +: 3] = vlan ? tci[15:13] : '0;
      status[ST_CFI] = vlan && tci[12];
      status[ST_EOF] = 1'b1;
      status[11:0] = lenAdj[11:0];
    end
  end
  a_fcs_length: assert property (@(posedge clk) disable iff (rst)
    eof && netCfg[CFG_NOFCS] && !netCfg[CFG_JUMBO] |-> status[11:0] == 12'(len - FCS_BYTES))
    else $error("length not reduced by four");
  a_partial_status: assert property (@(posedge clk) disable iff (rst)
    !eof |-> status[31:15] == '0 && status[11:0] == '0)
    else $error("non-final buffer carries end status");
endmodule : erdm_status_word
`default_nettype wire
